// file: common/sample_queue_defs.vh
/*
 Constants for the sample queue, scaling and interrupt request block:
 register indices, field positions, reset values and queue geometry.
 Assumes inclusion by bare name from design files.
*/
`ifndef SAMPLE_QUEUE_DEFS_VH
`define SAMPLE_QUEUE_DEFS_VH

`define ADDR_RESULT_FIRST 8'h02
`define ADDR_RESULT_LAST 8'h07
`define ADDR_FLAGS 8'h08
`define ADDR_SCALE_WIDTH 8'h15
`define ADDR_QUEUE_CTRL 8'h16
`define ADDR_IRQ_CTRL 8'h17
`define ADDR_QUEUE_READ 8'h18
`define ADDR_QUEUE_COUNT 8'h19

`define RST_SCALE_WIDTH 8'h00
`define RST_QUEUE_CTRL 8'h00
`define RST_IRQ_CTRL 8'h00

`define WIDTH_SEL_LSB 0
`define WIDTH_SEL_MSB 2
`define RANGE_SEL_LSB 4
`define RANGE_SEL_MSB 6
`define WIDTH_6 3'h0
`define WIDTH_7 3'h1
`define WIDTH_8 3'h2
`define WIDTH_12 3'h4
`define WIDTH_14 3'h5

`define QTH_LSB 0
`define QTH_MSB 4
`define QMODE_BIT 5
`define QEN_BIT 6
`define QCLR_BIT 7

`define IRQ_DRIVE_BIT 0
`define IRQ_POL_BIT 1
`define IRQ_WAKE_BIT 2
`define IRQ_NEW_BIT 3
`define IRQ_EMPTY_BIT 4
`define IRQ_FULL_BIT 5
`define IRQ_LEVEL_BIT 6
`define IRQ_CWATCH_BIT 7

`define FLAG_WAKE_BIT 2
`define FLAG_NEW_BIT 3
`define FLAG_EMPTY_BIT 4
`define FLAG_FULL_BIT 5
`define FLAG_LEVEL_BIT 6
`define FLAG_CWATCH_BIT 7

`define QUEUE_DEPTH 32
`define QUEUE_WIDTH 12
`define QUEUE_AW 5
`define QUEUE_CW 6
`define QUEUE_FULL_COUNT 6'h20

`endif

// file: test/accel_sample_fifo_irq_ctrl_tb.sv
/*
 Self-checking bench: register reads, width scaling, queue, pin.
 Assumes the block header and the pin model in test/.
*/
`timescale 1ns/10ps
`default_nettype none
module accel_sample_fifo_irq_ctrl_tb;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, sample_valid = 0;
  logic wake = 0, watch = 0, comb = 0, cont = 0, rd_seen = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [1:0] sample_axis = 2'h0, ax;
  logic [13:0] sample_data = 14'h0000, d;
  logic signed [13:0] r;
  wire [7:0] reg_rdata;
  wire [2:0] range_select;
  wire pin_out, pin_oe, line;
  logic [23:0] exp_q[$];
  int miscompares = 0, comparisons = 0, cycles = 0, w;
  accel_sample_fifo_irq_ctrl dut (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample_axis(sample_axis), .sample_data(sample_data),
    .motion_wake_event(wake), .motion_watch_event(watch),
    .continuous_active_state(cont), .combined_watch_active_state(comb),
    .range_select(range_select), .irq_request_pin_out(pin_out),
    .irq_request_pin_oe(pin_oe));
  irq_line_model host (.drv(pin_out), .oe(pin_oe), .line(line));
  initial forever #25 clk = ~clk;
  task end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    rd_seen <= reg_rd;
    if (cycles == 5000) begin
      miscompares++;
      end_sim;
    end
  end
  task check_rd(input [23:0] e);
    comparisons++;
    if ((reg_rdata & e[7:0]) !== (e[15:8] & e[7:0])) begin
      miscompares++;
      $display("[ERR] reg %h expected %h seen %h", e[23:16], e[15:8], reg_rdata);
    end
  endtask
  // Read data is settled half a cycle after the taking edge
  always @(negedge clk) if (rd_seen) check_rd(exp_q.pop_front());
  task check_pin(input e);
    repeat (4) @(negedge clk);
    comparisons++;
    if (line !== e) begin
      miscompares++;
      $display("[ERR] pin expected %b seen %b", e, line);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] m);
    exp_q.push_back({a, e, m});
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
  endtask
  task smp(input [1:0] a, input [13:0] v);
    @(negedge clk);
    sample_axis = a;
    sample_data = v;
    sample_valid = 1;
    @(negedge clk);
    sample_valid = 0;
  endtask
  initial begin
    void'($urandom(89));
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 0;
    rd(8'h15, 8'h00, 8'hff);
    rd(8'h16, 8'h00, 8'hff);
    rd(8'h17, 8'h00, 8'hff);
    rd(8'h1f, 8'h00, 8'hff);
    wr(8'h15, 8'hff);
    rd(8'h15, 8'h77, 8'hff);
    for (int c = 0; c < 8; c++) begin
      if (c == 3) continue;
      w = (c < 3) ? 6 + c : (c == 5) ? 14 : 12;
      d = 14'($urandom);
      ax = 2'($urandom % 3);
      r = $signed(d) >>> (14 - w);
      wr(8'h15, {5'h00, c[2:0]});
      smp(ax, d);
      rd({5'h00, 2'(ax + 2'h1), 1'b0}, r[7:0], 8'hff);
      rd({5'h00, 2'(ax + 2'h1), 1'b1}, 8'(r >>> 8), 8'hff);
    end
    // Queue on with 14-bit selection: entries fall back to 12 bits
    wr(8'h15, 8'h05);
    wr(8'h16, 8'h45);
    rd(8'h08, 8'h10, 8'h70);
    d = 14'($urandom);
    for (int i = 0; i < 33; i++) smp(2'h0, i == 0 ? d : 14'($urandom));
    rd(8'h19, 8'h20, 8'hff);
    rd(8'h08, 8'h68, 8'h78);
    rd(8'h18, d[9:2], 8'hff);
    rd(8'h19, 8'h1f, 8'hff);
    wr(8'h16, 8'hc5);
    wr(8'h16, 8'h45);
    rd(8'h19, 8'h00, 8'hff);
    wr(8'h16, 8'h64);
    repeat (6) smp(2'h1, 14'($urandom));
    rd(8'h19, 8'h04, 8'hff);
    rd(8'h08, 8'h40, 8'h70);
    wr(8'h16, 8'hc4);
    wr(8'h16, 8'h44);
    for (int p = 0; p < 4; p++) begin
      wr(8'h17, {6'h04, p[1:0]});
      check_pin(p[1]);
    end
    wr(8'h17, 8'h20);
    check_pin(1'b1);
    wr(8'h16, 8'h00);
    rd(8'h08, 8'h10, 8'h70);
    wr(8'h17, 8'h11);
    check_pin(1'b1);
    wr(8'h17, 8'h09);
    smp(2'h2, 14'($urandom));
    check_pin(1'b0);
    rd(8'h08, 8'h08, 8'h08);
    check_pin(1'b1);
    wr(8'h17, 8'h81);
    watch = 1;
    repeat (4) check_pin(1'b1);
    watch = 0;
    comb = 1;
    check_pin(1'b1);
    watch = 1;
    repeat (2) check_pin(1'b0);
    wr(8'h17, 8'h05);
    cont = 1;
    repeat (4) @(negedge clk);
    wake = 1;
    repeat (2) check_pin(1'b0);
    rd(8'h08, 8'h84, 8'h84);
    wake = 0;
    repeat (4) @(negedge clk);
    end_sim;
  end
endmodule // accel_sample_fifo_irq_ctrl_tb
bind accel_sample_fifo_irq_ctrl irq_ctrl_assertions chk (.clk(clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .motion_wake_event(motion_wake_event),
  .continuous_active_state(continuous_active_state),
  .range_select(range_select),
  .irq_request_pin_out(irq_request_pin_out),
  .irq_request_pin_oe(irq_request_pin_oe));
`default_nettype wire

// file: test/irq_ctrl_assertions.sv
/*
 Checker for the register and request pin ports of the block.
 Assumes it is bound onto the block top; one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic motion_wake_event,
  input wire logic continuous_active_state,
  input wire logic [2:0] range_select,
  input wire logic irq_request_pin_out,
  input wire logic irq_request_pin_oe
);
  logic [7:0] ctl;
  logic [1:0] calm;
  wire [2:0] rng_in = reg_wdata[6:4];
  wire rng_wr = reg_wr && reg_addr == 8'h15;
  // Calm counts edges since the last control write, so pin checks
  // wait out the register and source pipeline
  always @(posedge clk) begin
    if (reset) begin
      ctl <= 8'h00;
      calm <= 2'h0;
    end else if (reg_wr && reg_addr == 8'h17) begin
      ctl <= reg_wdata;
      calm <= 2'h0;
    end else if (calm != 2'h3) begin
      calm <= calm + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  push_pull_a: assert property (calm == 2'h3 && ctl[0] |-> irq_request_pin_oe)
    else $error("push-pull pin not driven");
  open_drain_a: assert property (calm == 2'h3 && !ctl[0] && irq_request_pin_oe
    |-> irq_request_pin_out == ctl[1])
    else $error("open-drain pin driven to idle level");
  idle_pin_a: assert property (calm == 2'h3 && ctl[7:2] == 6'h00 |->
    irq_request_pin_out == !ctl[1] && irq_request_pin_oe == ctl[0])
    else $error("pin active with all sources off");
  // Wake only counts while the device is already in the continuous state
  wake_pin_a: assert property (calm == 2'h3 && ctl[2] &&
    continuous_active_state && $rose(motion_wake_event)
    |-> ##[2:8] irq_request_pin_out == ctl[1])
    else $error("wake request missing");
  range_set_a: assert property (rng_wr |=> range_select == $past(rng_in))
    else $error("range output not updated");
  range_hold_a: assert property (!rng_wr |=> $stable(range_select))
    else $error("range output moved without write");
  ctl_read_a: assert property (reg_rd && reg_addr == 8'h17 |=> reg_rdata == ctl)
    else $error("control readback wrong");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h1f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // irq_ctrl_assertions
`default_nettype wire

// file: test/irq_line_model.sv
/*
 Host side of the request line: pull-up and the level the host sees.
 Assumes the device drives the line only while its enable is high.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_line_model (
  input wire logic drv,
  input wire logic oe,
  output logic line
);
  // Pull-up wins whenever the device lets go of the line
  assign line = oe ? drv : 1'b1;
endmodule // irq_line_model
`default_nettype wire

// file: verilog/accel_sample_fifo_irq_ctrl.v
/*
 Configuration, 32-entry sample queue and interrupt request logic of a
 three-axis motion sensor. Assumes a register access engine on the same
 clock drives reg_addr/reg_wr/reg_rd; samples arrive from the converter
 as 14-bit two's complement words, one axis per strobe, on the same clock.
 Motion events come from a separate detector and are synchronised here.
*/
// Behaviour
// - Results are sign-extended two's complement at any width.
// - Per-axis results sit at addresses 0x02 through 0x07.
// - Width field: 000=6, 001=7, 010=8, 100=12, 101=14 bits.
// - With queue enabled, 14-bit selection is limited to 12 bits.
// - Each queue entry is 12 bits wide.
// - Range field bits 6:4 selects 2, 4, 8, 16 or 12 g.
// - Queue enable gates all queue behaviour except the clear bit.
// - With queue disabled, queue flags at 0x08 show default values.
// - Mode 0: queue stores samples while space remains.
// - Mode 1: queue stops storing once count reaches threshold.
// - Queue disabled: samples go straight to result registers.
// - Queue enabled: every sample written to queue if room exists and clear bit is 0.
// - Clear bit empties pointers and zeroes all queue contents.
// - Drive bit: 0 open-drain, 1 push-pull request pin.
// - Polarity bit: 0 active low, 1 active high request.
// - Wake interrupt fires on a wake motion event while already in continuous state.
// - New-sample interrupt fires on each sample written anywhere.
// - Empty interrupt fires only when queue count equals zero.
// - Full interrupt fires only when queue count reaches 32.
// - Level interrupt fires when count reaches programmed threshold.
// - Combined-watch interrupt fires on motion in combined state.
`timescale 1ns/10ps
`default_nettype none
`include "sample_queue_defs.vh"

module accel_sample_fifo_irq_ctrl (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire sample_valid,
  input wire [1:0] sample_axis,
  input wire [13:0] sample_data,
  input wire motion_wake_event,
  input wire motion_watch_event,
  input wire continuous_active_state,
  input wire combined_watch_active_state,
  output wire [2:0] range_select,
  output wire irq_request_pin_out,
  output wire irq_request_pin_oe
);

  reg [7:0] scale_and_width_control;
  reg [7:0] sample_queue_control;
  reg [7:0] interrupt_source_control;
  reg [7:0] result [0:5];
  reg [`QUEUE_WIDTH-1:0] queue_mem [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_AW-1:0] wr_ptr;
  reg [`QUEUE_AW-1:0] rd_ptr;
  reg [`QUEUE_CW-1:0] count;
  reg new_flag;
  reg wake_flag;
  reg cwatch_flag;
  reg wake_meta, wake_sync, wake_prev;
  reg watch_meta, watch_sync, watch_prev;
  reg cstate_meta, cstate_sync;
  reg sstate_meta, sstate_sync;
  reg irq_active;
  integer i;
  integer j;

  wire [2:0] sample_width_select;
  wire [4:0] queue_threshold_level;
  wire queue_enable;
  wire queue_mode;
  wire queue_clear;
  wire irq_pin_drive_type;
  wire irq_pin_polarity;
  wire irq_new_sample_en;
  wire irq_queue_level_en;
  wire irq_combined_watch_en;
  wire [2:0] eff_width;
  wire [13:0] shaped;
  wire [`QUEUE_WIDTH-1:0] queue_word;
  wire queue_full;
  wire queue_empty;
  wire level_hit;
  wire room;
  wire do_push;
  wire do_pop;
  wire wake_rise;
  wire watch_rise;
  wire flag_read;
  wire [7:0] flags_value;
  wire any_irq;
  wire result_hit;
  wire [7:0] result_offset;

  assign sample_width_select =
    scale_and_width_control[`WIDTH_SEL_MSB:`WIDTH_SEL_LSB];
  assign range_select =
    scale_and_width_control[`RANGE_SEL_MSB:`RANGE_SEL_LSB];
  assign queue_threshold_level = sample_queue_control[`QTH_MSB:`QTH_LSB];
  assign queue_enable = sample_queue_control[`QEN_BIT];
  assign queue_mode = sample_queue_control[`QMODE_BIT];
  assign queue_clear = sample_queue_control[`QCLR_BIT];
  assign irq_pin_drive_type = interrupt_source_control[`IRQ_DRIVE_BIT];
  assign irq_pin_polarity = interrupt_source_control[`IRQ_POL_BIT];
  assign irq_new_sample_en = interrupt_source_control[`IRQ_NEW_BIT];
  assign irq_queue_level_en = interrupt_source_control[`IRQ_LEVEL_BIT];
  assign irq_combined_watch_en = interrupt_source_control[`IRQ_CWATCH_BIT];

  // Keep the top bits of the converter word and sign-extend to 14 bits
  function [13:0] shape_sample;
    input [13:0] raw;
    input [2:0] sel;
    begin
      case (sel)
        `WIDTH_6: shape_sample = {{8{raw[13]}}, raw[13:8]};
        `WIDTH_7: shape_sample = {{7{raw[13]}}, raw[13:7]};
        `WIDTH_8: shape_sample = {{6{raw[13]}}, raw[13:6]};
        `WIDTH_12: shape_sample = {{2{raw[13]}}, raw[13:2]};
        `WIDTH_14: shape_sample = raw;
        default: shape_sample = {{2{raw[13]}}, raw[13:2]};
      endcase
    end
  endfunction

  // Reserved width codes fall back to 12 bits; 14 is clipped with queue on
  assign eff_width = (queue_enable && sample_width_select == `WIDTH_14) ?
    `WIDTH_12 : sample_width_select;
  assign shaped = shape_sample(sample_data, eff_width);
  assign queue_word = shaped[`QUEUE_WIDTH-1:0];

  assign queue_full = (count == `QUEUE_FULL_COUNT);
  assign queue_empty = (count == 6'h00);
  assign level_hit = (count >= {1'b0, queue_threshold_level});
  // Watermark mode drops samples once the threshold is reached
  assign room = !queue_full && !(queue_mode && level_hit);
  assign do_push = queue_enable && !queue_clear && sample_valid &&
    room;
  assign do_pop = queue_enable && !queue_clear && reg_rd &&
    reg_addr == `ADDR_QUEUE_READ && !queue_empty;

  assign flag_read = reg_rd && reg_addr == `ADDR_FLAGS;
  assign result_hit = reg_addr >= `ADDR_RESULT_FIRST &&
    reg_addr <= `ADDR_RESULT_LAST;
  assign result_offset = reg_addr - `ADDR_RESULT_FIRST;
  assign wake_rise = wake_sync && !wake_prev;
  assign watch_rise = watch_sync && !watch_prev;

  // Disabled queue reports empty as its default state
  assign flags_value = {cwatch_flag,
    queue_enable && level_hit,
    queue_enable && queue_full,
    !queue_enable || queue_empty,
    new_flag, wake_flag, 2'b00};

  assign any_irq =
    (interrupt_source_control[`IRQ_WAKE_BIT] && wake_flag) ||
    (irq_new_sample_en && new_flag) ||
    (interrupt_source_control[`IRQ_EMPTY_BIT] && queue_enable &&
     queue_empty) ||
    (interrupt_source_control[`IRQ_FULL_BIT] && queue_enable &&
     queue_full) ||
    (irq_queue_level_en && queue_enable && level_hit) ||
    (irq_combined_watch_en && cwatch_flag);

  // Open-drain only ever pulls the line to its active level
  assign irq_request_pin_out = irq_pin_polarity ? irq_active :
    !irq_active;
  assign irq_request_pin_oe = irq_pin_drive_type | irq_active;

  always @(posedge clk) begin
    if (reset) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      wake_prev <= 1'b0;
      watch_meta <= 1'b0;
      watch_sync <= 1'b0;
      watch_prev <= 1'b0;
      cstate_meta <= 1'b0;
      cstate_sync <= 1'b0;
      sstate_meta <= 1'b0;
      sstate_sync <= 1'b0;
    end else begin
      wake_meta <= motion_wake_event;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
      watch_meta <= motion_watch_event;
      watch_sync <= watch_meta;
      watch_prev <= watch_sync;
      cstate_meta <= continuous_active_state;
      cstate_sync <= cstate_meta;
      sstate_meta <= combined_watch_active_state;
      sstate_sync <= sstate_meta;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      scale_and_width_control <= `RST_SCALE_WIDTH;
      sample_queue_control <= `RST_QUEUE_CTRL;
      interrupt_source_control <= `RST_IRQ_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_SCALE_WIDTH: scale_and_width_control <= reg_wdata & 8'h77;
        `ADDR_QUEUE_CTRL: sample_queue_control <= reg_wdata;
        `ADDR_IRQ_CTRL: interrupt_source_control <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Event flags are cleared by reading 0x08; a new event wins the clear
  always @(posedge clk) begin
    if (reset) begin
      new_flag <= 1'b0;
      wake_flag <= 1'b0;
      cwatch_flag <= 1'b0;
      irq_active <= 1'b0;
    end else begin
      new_flag <= (sample_valid && (do_push || !queue_enable)) ||
        (new_flag && !flag_read);
      wake_flag <= (wake_rise && cstate_sync) ||
        (wake_flag && !flag_read);
      cwatch_flag <= (watch_rise && sstate_sync) ||
        (cwatch_flag && !flag_read);
      irq_active <= any_irq;
    end
  end

  // Results land directly only while the queue is off
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 6; i = i + 1)
        result[i] <= 8'h00;
    end else if (sample_valid && !queue_enable && sample_axis != 2'b11) begin
      result[{sample_axis, 1'b0}] <= shaped[7:0];
      // High byte carries the sign into its two spare bits
      result[{sample_axis, 1'b1}] <= {{2{shaped[13]}}, shaped[13:8]};
    end
  end

  // Clear acts on the next edge regardless of the enable; the queue has no
  // separate clock so a true asynchronous clear is not offered
  always @(posedge clk) begin
    if (reset || queue_clear) begin
      wr_ptr <= {`QUEUE_AW{1'b0}};
      rd_ptr <= {`QUEUE_AW{1'b0}};
      count <= {`QUEUE_CW{1'b0}};
      for (j = 0; j < `QUEUE_DEPTH; j = j + 1)
        queue_mem[j] <= {`QUEUE_WIDTH{1'b0}};
    end else begin
      if (do_push) begin
        queue_mem[wr_ptr] <= queue_word;
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (do_pop)
        rd_ptr <= rd_ptr + 5'h01;
      if (do_push && !do_pop)
        count <= count + 6'h01;
      else if (do_pop && !do_push)
        count <= count - 6'h01;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (result_hit) begin
        reg_rdata <= result[result_offset[2:0]];
      end else begin
        case (reg_addr)
          `ADDR_FLAGS: reg_rdata <= flags_value;
          `ADDR_SCALE_WIDTH: reg_rdata <= scale_and_width_control;
          `ADDR_QUEUE_CTRL: reg_rdata <= sample_queue_control;
          `ADDR_IRQ_CTRL: reg_rdata <= interrupt_source_control;
          `ADDR_QUEUE_READ:
            reg_rdata <= queue_mem[rd_ptr][7:0];
          `ADDR_QUEUE_COUNT: reg_rdata <= {2'b00, count};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // accel_sample_fifo_irq_ctrl

`default_nettype wire
